// >>> src/pssc_pkg.sv
package pssc_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_WAKE2 = 8'h14;
    localparam logic [7:0] ADDR_AWAKE = 8'h18;
    localparam logic [7:0] ADDR_SLEEP1 = 8'h1C;
    localparam logic [7:0] ADDR_SLEEP2 = 8'h20;
    localparam logic [7:0] ADDR_CTRL = 8'h28;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DWELL_LSB = 16;
    localparam int DWELL_W = 5;
    localparam int BIT_CLK_OFF = 14;
    localparam int BIT_ANA_PFM = 9;
    localparam int BIT_CORE_PFM = 8;
    localparam int BIT_IO_EN = 5;
    localparam int BIT_PLL_EN = 4;
    localparam int BIT_ANA_EN = 1;
    localparam int BIT_CORE_EN = 0;
    localparam int BIT_SLEEP_REQ = 1;
    localparam int STATE_LSB = 16;
    localparam int STATE_W = 3;

    // ----------------------------------------
    // Reset values and writable masks
    // ----------------------------------------
    localparam logic [31:0] RST_WAKE2 = 32'h0010_0033;
    localparam logic [31:0] RST_AWAKE = 32'h0000_0033;
    localparam logic [31:0] RST_SLEEP1 = 32'h0010_0022;
    localparam logic [31:0] RST_SLEEP2 = 32'h0010_0002;
    localparam logic [31:0] MASK_TIMED = 32'h001F_4331;
    localparam logic [31:0] MASK_AWAKE = 32'h0000_4331;
    // Settings for states whose registers live outside this block
    localparam logic [31:0] CFG_ASLEEP = 32'h0010_0000;
    localparam logic [31:0] CFG_WAKE1 = 32'h0010_0020;

    // ----------------------------------------
    // State codes and one-hot states
    // ----------------------------------------
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [2:0] CODE_ASLEEP = 3'h1;
    localparam logic [2:0] CODE_WAKE1 = 3'h2;
    localparam logic [2:0] CODE_WAKE2 = 3'h3;
    localparam logic [2:0] CODE_AWAKE_WAIT = 3'h4;
    localparam logic [2:0] CODE_AWAKE = 3'h5;
    localparam logic [2:0] CODE_SLEEP1 = 3'h6;
    localparam logic [2:0] CODE_SLEEP2 = 3'h7;

    typedef enum logic [7:0] {
        ST_RESET = 8'h01,
        ST_ASLEEP = 8'h02,
        ST_WAKE1 = 8'h04,
        ST_WAKE2 = 8'h08,
        ST_AWAKE_WAIT = 8'h10,
        ST_AWAKE = 8'h20,
        ST_SLEEP1 = 8'h40,
        ST_SLEEP2 = 8'h80
    } pssc_state_e;

endpackage : pssc_pkg

// >>> src/pssc_top.sv
`timescale 1ns/1ps
module pssc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic seq_tick,
    input wire logic wake_event,
    input wire logic first_wake_done,
    input wire logic core_good,
    input wire logic analog_good,
    input wire logic pll_good,
    input wire logic io_good,
    output logic core_conv_en,
    output logic core_conv_pfm,
    output logic analog_conv_en,
    output logic analog_conv_pfm,
    output logic io_supply_en,
    output logic pll_reg_en,
    output logic core_clk_off,
    output logic [pssc_pkg::STATE_W-1:0] seq_state
);
    import pssc_pkg::*;

    // ----------------------------------------
    // Configuration storage
    // ----------------------------------------
    logic [31:0] cfg_reg [0:3];
    logic sleep_req_reg;
    pssc_state_e state_reg;
    pssc_state_e state_next;
    logic [31:0] cnt_reg;
    logic dwell_met_reg;
    logic [31:0] cur_cfg;
    logic [31:0] dwell_last;
    logic dwell_end;
    logic all_good;
    logic [2:0] state_code;

    function automatic logic [31:0] cfg_of(input pssc_state_e st, input logic [31:0] w2,
                                           input logic [31:0] aw, input logic [31:0] s1,
                                           input logic [31:0] s2);
        logic [31:0] c;
        c = CFG_ASLEEP;
        case (st)
            ST_WAKE1: c = CFG_WAKE1;
            ST_WAKE2: c = w2;
            ST_AWAKE_WAIT: c = aw;
            ST_AWAKE: c = aw;
            ST_SLEEP1: c = s1;
            ST_SLEEP2: c = s2;
            default: c = CFG_ASLEEP;
        endcase
        return c;
    endfunction : cfg_of

    // Read-only and reserved bits keep their reset value, so no write can disturb them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg[0] <= RST_WAKE2;
            cfg_reg[1] <= RST_AWAKE;
            cfg_reg[2] <= RST_SLEEP1;
            cfg_reg[3] <= RST_SLEEP2;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_WAKE2: cfg_reg[0] <= (reg_wdata & MASK_TIMED) | (RST_WAKE2 & ~MASK_TIMED);
                ADDR_AWAKE: cfg_reg[1] <= (reg_wdata & MASK_AWAKE) | (RST_AWAKE & ~MASK_AWAKE);
                ADDR_SLEEP1: cfg_reg[2] <= (reg_wdata & MASK_TIMED) | (RST_SLEEP1 & ~MASK_TIMED);
                ADDR_SLEEP2: cfg_reg[3] <= (reg_wdata & MASK_TIMED) | (RST_SLEEP2 & ~MASK_TIMED);
                default: ;
            endcase
        end
    end

    // Self-clearing; a request outside the awake state is simply dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_req_reg <= 1'b0;
        end else begin
            sleep_req_reg <= reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[BIT_SLEEP_REQ];
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_WAKE2: reg_rdata <= cfg_reg[0];
                ADDR_AWAKE: reg_rdata <= cfg_reg[1];
                ADDR_SLEEP1: reg_rdata <= cfg_reg[2];
                ADDR_SLEEP2: reg_rdata <= cfg_reg[3];
                ADDR_CTRL: reg_rdata <= {13'h0000, seq_state, 16'h0000};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Dwell timing
    // ----------------------------------------
    assign cur_cfg = cfg_of(state_reg, cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]);
    // Largest target 2^31 - 1 still fits the 32-bit counter
    assign dwell_last = (32'h0000_0001 << cur_cfg[DWELL_LSB +: DWELL_W]) - 32'h0000_0001;
    assign dwell_end = seq_tick && (cnt_reg == dwell_last);
    assign all_good = (core_good || !cur_cfg[BIT_CORE_EN])
                   && (analog_good || !cur_cfg[BIT_ANA_EN])
                   && (pll_good || !cur_cfg[BIT_PLL_EN])
                   && (io_good || !cur_cfg[BIT_IO_EN]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= 32'h0000_0000;
        end else if (state_next != state_reg) begin
            cnt_reg <= 32'h0000_0000;
        end else if (seq_tick && !dwell_met_reg && !dwell_end) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    // Minimum time, once reached, stays met while supplies come up
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dwell_met_reg <= 1'b0;
        end else if (state_next != state_reg) begin
            dwell_met_reg <= 1'b0;
        end else if (dwell_end) begin
            dwell_met_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: state_next = ST_WAKE1;
            ST_ASLEEP: begin
                if (wake_event) begin
                    state_next = ST_WAKE1;
                end
            end
            ST_WAKE1: begin
                if (first_wake_done) begin
                    state_next = ST_WAKE2;
                end
            end
            ST_WAKE2: begin
                if ((dwell_met_reg || dwell_end) && all_good) begin
                    state_next = ST_AWAKE_WAIT;
                end
            end
            ST_AWAKE_WAIT: state_next = ST_AWAKE;
            ST_AWAKE: begin
                if (sleep_req_reg) begin
                    state_next = ST_SLEEP1;
                end
            end
            ST_SLEEP1: begin
                if (dwell_end) begin
                    state_next = ST_SLEEP2;
                end
            end
            ST_SLEEP2: begin
                if (dwell_end) begin
                    state_next = ST_ASLEEP;
                end
            end
            default: state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Coded from the next state so seq_state turns at the same edge as state_reg
    always_comb begin
        case (state_next)
            ST_RESET: state_code = CODE_RESET;
            ST_ASLEEP: state_code = CODE_ASLEEP;
            ST_WAKE1: state_code = CODE_WAKE1;
            ST_WAKE2: state_code = CODE_WAKE2;
            ST_AWAKE_WAIT: state_code = CODE_AWAKE_WAIT;
            ST_AWAKE: state_code = CODE_AWAKE;
            ST_SLEEP1: state_code = CODE_SLEEP1;
            ST_SLEEP2: state_code = CODE_SLEEP2;
            default: state_code = CODE_RESET;
        endcase
    end

    // ----------------------------------------
    // Supply and clock outputs
    // ----------------------------------------
    // Driven from the next state's settings so pins change together with the state
    logic [31:0] nxt_cfg;
    assign nxt_cfg = cfg_of(state_next, cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_conv_en <= 1'b0;
            core_conv_pfm <= 1'b0;
            analog_conv_en <= 1'b0;
            analog_conv_pfm <= 1'b0;
            io_supply_en <= 1'b0;
            pll_reg_en <= 1'b0;
            core_clk_off <= 1'b0;
            seq_state <= CODE_RESET;
        end else begin
            core_conv_en <= nxt_cfg[BIT_CORE_EN];
            core_conv_pfm <= nxt_cfg[BIT_CORE_PFM];
            analog_conv_en <= nxt_cfg[BIT_ANA_EN];
            analog_conv_pfm <= nxt_cfg[BIT_ANA_PFM];
            io_supply_en <= nxt_cfg[BIT_IO_EN];
            pll_reg_en <= nxt_cfg[BIT_PLL_EN];
            core_clk_off <= nxt_cfg[BIT_CLK_OFF];
            seq_state <= state_code;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [31:0] cfg_wake2;
    assign cfg_wake2 = cfg_reg[0];

    a_sleep1_exit: assert property (state_reg == ST_SLEEP1 && dwell_end |=> state_reg == ST_SLEEP2)
        else $error("first sleep phase did not end on its dwell");
    a_sleep2_hold: assert property (state_reg == ST_SLEEP2 && !dwell_end |=> state_reg == ST_SLEEP2)
        else $error("second sleep phase left early");
    a_dwell_one: assert property (state_reg == ST_SLEEP2 && cur_cfg[20:16] == 5'h00 && seq_tick
        |=> state_reg == ST_ASLEEP)
        else $error("zero dwell did not last one tick");
    a_wake2_good: assert property (state_reg == ST_WAKE2 && !all_good |=> state_reg == ST_WAKE2)
        else $error("second wake left without power good");
    a_wake2_min: assert property (state_reg == ST_WAKE2 && !dwell_met_reg && !dwell_end
        |=> state_reg == ST_WAKE2)
        else $error("second wake left before its dwell");
    a_awake_path: assert property (state_reg == ST_AWAKE_WAIT |=> state_reg == ST_AWAKE)
        else $error("awake wait did not step to awake");
    a_sleep_req: assert property (state_reg == ST_AWAKE && sleep_req_reg |=> state_reg == ST_SLEEP1
        ##0 seq_state == CODE_SLEEP1)
        else $error("sleep request not taken from awake");
    a_ro_bit: assert property (reg_wr && reg_addr == ADDR_WAKE2 |=> cfg_wake2[BIT_ANA_EN]
        == RST_WAKE2[BIT_ANA_EN] && (cfg_wake2 & ~MASK_TIMED) == (RST_WAKE2 & ~MASK_TIMED))
        else $error("read-only or reserved bit changed by a write");
    a_read_data: assert property (reg_rd && reg_addr == ADDR_WAKE2 |=> reg_rdata == $past(cfg_wake2))
        else $error("read data wrong");
    a_out_follow: assert property ($changed(state_reg) |-> core_clk_off == cur_cfg[BIT_CLK_OFF]
        && io_supply_en == cur_cfg[BIT_IO_EN] && core_conv_pfm == cur_cfg[BIT_CORE_PFM])
        else $error("outputs do not follow current state settings");
    a_rail_follow: assert property ($changed(state_reg) |-> pll_reg_en == cur_cfg[BIT_PLL_EN]
        && analog_conv_pfm == cur_cfg[BIT_ANA_PFM] && analog_conv_en == cur_cfg[BIT_ANA_EN]
        && core_conv_en == cur_cfg[BIT_CORE_EN])
        else $error("rail enables do not follow current state settings");
    // The pin code must never lag the internal state, or software sees a stale phase
    a_code_match: assert property (((state_reg == ST_AWAKE) == (seq_state == CODE_AWAKE))
        && ((state_reg == ST_SLEEP2) == (seq_state == CODE_SLEEP2)))
        else $error("state code out of step with the sequencer");
    a_awake_stay: assert property (state_reg == ST_AWAKE && !sleep_req_reg
        |=> state_reg == ST_AWAKE)
        else $error("awake state left without a sleep request");
    a_sleep_entry: assert property (state_reg != ST_AWAKE && state_reg != ST_SLEEP1
        |=> state_reg != ST_SLEEP1)
        else $error("first sleep phase entered from a state other than awake");
    a_sleep1_hold: assert property (state_reg == ST_SLEEP1 && !dwell_end
        |=> state_reg == ST_SLEEP1)
        else $error("first sleep phase left early");
    a_sleep2_exit: assert property (state_reg == ST_SLEEP2 && dwell_end
        |=> state_reg == ST_ASLEEP)
        else $error("second sleep phase did not end on its dwell");
    a_wake1_exit: assert property (state_reg == ST_WAKE1 && first_wake_done
        |=> state_reg == ST_WAKE2)
        else $error("first wake phase did not step to second wake");
    // A tick-less cycle must not count, whatever the fast clock does
    a_tick_hold: assert property (state_reg == ST_SLEEP1 && !seq_tick
        |=> state_reg == ST_SLEEP1)
        else $error("sleep phase ended without a sequencer tick");
    a_cnt_clear: assert property ($changed(state_reg) |-> cnt_reg == 32'h0000_0000)
        else $error("dwell count not restarted on state entry");
    a_met_clear: assert property ($changed(state_reg) |-> !dwell_met_reg)
        else $error("minimum time flag carried into a new state");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_rsvd_read: assert property (reg_rd && reg_addr == ADDR_AWAKE
        |=> reg_rdata[31:15] == 17'h0_0000)
        else $error("reserved awake bits read nonzero");

    c_reach_awake: cover property (state_reg == ST_AWAKE_WAIT ##1 state_reg == ST_AWAKE);
    c_reach_asleep: cover property (state_reg == ST_SLEEP2 ##1 state_reg == ST_ASLEEP);
    c_wake2_wait: cover property (state_reg == ST_WAKE2 && dwell_met_reg && !all_good);
    // A request outside awake is dropped; seeing it proves the drop path ran
    c_req_lost: cover property (state_reg == ST_WAKE1 && sleep_req_reg);
    c_go_sleep: cover property (state_reg == ST_AWAKE && sleep_req_reg ##1 state_reg == ST_SLEEP1);

endmodule : pssc_top

// >>> tb/pssc_supply_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Supplies and regulators behind the block
// ----------------------------------------
module pssc_supply_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic core_conv_en,
    input wire logic analog_conv_en,
    input wire logic pll_reg_en,
    input wire logic io_supply_en,
    output logic core_good,
    output logic analog_good,
    output logic pll_good,
    output logic io_good
);
    logic [3:0] en_now;
    logic [3:0] hist [0:15];
    logic [3:0] ramp_done;
    assign en_now = {io_supply_en, pll_reg_en, analog_conv_en, core_conv_en};
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 16; i++) hist[i] <= 4'h0;
        end else begin
            hist[0] <= en_now;
            for (int i = 1; i < 16; i++) hist[i] <= hist[i-1];
        end
    end
    // Slow rails need 16 cycles of steady enable; a dropped enable loses good at once
    always_comb begin
        ramp_done = en_now & hist[0];
        if (slow) begin
            for (int i = 1; i < 16; i++) ramp_done = ramp_done & hist[i];
        end
    end
    assign {io_good, pll_good, analog_good, core_good} = ramp_done;
endmodule : pssc_supply_model

// >>> tb/tb_power_state_supply_config.sv
`timescale 1ns/1ps
module tb_power_state_supply_config;
    import pssc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk, sys_rst, reg_wr, reg_rd, seq_tick, wake_event, first_wake_done, slow;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic core_good, analog_good, pll_good, io_good;
    logic core_conv_en, core_conv_pfm, analog_conv_en, analog_conv_pfm;
    logic io_supply_en, pll_reg_en, core_clk_off;
    logic [2:0] seq_state;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    // Address, reset value, write data, readback
    logic [31:0] rows [5][4] = '{
        '{32'h0000_0014, 32'h0010_0033, 32'hFFFF_FFFF, 32'h001F_4333},
        '{32'h0000_0018, 32'h0000_0033, 32'hFFFF_FFFF, 32'h0000_4333},
        '{32'h0000_001C, 32'h0010_0022, 32'h0000_0000, 32'h0000_0002},
        '{32'h0000_0020, 32'h0010_0002, 32'h0000_4301, 32'h0000_4303},
        '{32'h0000_0030, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000}};
    pssc_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_tick(seq_tick),
        .wake_event(wake_event), .first_wake_done(first_wake_done), .core_good(core_good),
        .analog_good(analog_good), .pll_good(pll_good), .io_good(io_good),
        .core_conv_en(core_conv_en), .core_conv_pfm(core_conv_pfm),
        .analog_conv_en(analog_conv_en), .analog_conv_pfm(analog_conv_pfm),
        .io_supply_en(io_supply_en), .pll_reg_en(pll_reg_en), .core_clk_off(core_clk_off),
        .seq_state(seq_state));
    pssc_supply_model supplies (.clk(clk), .sys_rst(sys_rst), .slow(slow),
        .core_conv_en(core_conv_en), .analog_conv_en(analog_conv_en),
        .pll_reg_en(pll_reg_en), .io_supply_en(io_supply_en), .core_good(core_good),
        .analog_good(analog_good), .pll_good(pll_good), .io_good(io_good));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // Both bus tasks return at a falling edge, so callers sample settled values
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd_reg
    function automatic logic [31:0] ov(input logic [31:0] r);
        return {25'h0, r[14], r[9], r[8], r[5], r[4], r[1], r[0]};
    endfunction : ov
    // Waits for a state, checks its outputs, counts falling edges spent in it
    task automatic stay(input logic [2:0] c, input logic [31:0] r, input bit look,
                        input int lim, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (seq_state !== c && k < 200) begin
            @(negedge clk);
            k++;
        end
        chk("state", seq_state, c);
        if (look) chk("outputs", {25'h0, core_clk_off, analog_conv_pfm, core_conv_pfm,
            io_supply_en, pll_reg_en, analog_conv_en, core_conv_en}, ov(r));
        while (seq_state === c && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask : stay
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        close_out();
    end
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, wake_event, first_wake_done, slow} = 5'h0;
        seq_tick = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd_reg(rows[i][0][7:0], rd);
            chk("reset value", rd, rows[i][1]);
            wr_reg(rows[i][0][7:0], rows[i][2]);
            rd_reg(rows[i][0][7:0], rd);
            chk("readback", rd, rows[i][3]);
        end
        // Sleep request outside awake must be lost
        wr_reg(ADDR_CTRL, 32'h0000_0002);
        repeat (4) @(negedge clk);
        chk("state after early request", seq_state, CODE_WAKE1);
        wr_reg(ADDR_WAKE2, 32'h0002_0033);
        wr_reg(ADDR_AWAKE, 32'h0000_4331);
        wr_reg(ADDR_SLEEP1, 32'h0003_0122);
        wr_reg(ADDR_SLEEP2, 32'h0000_0200);
        @(posedge clk);
        first_wake_done <= 1'b1;
        @(negedge clk);
        stay(CODE_WAKE2, 32'h0002_0033, 1'b1, 99, n);
        chk("wake2 cycles", 32'(n), 32'h4);
        stay(CODE_AWAKE_WAIT, 32'h0, 1'b0, 99, n);
        chk("awake wait cycles", 32'(n), 32'h1);
        stay(CODE_AWAKE, 32'h0000_4333, 1'b1, 10, n);
        chk("awake cycles", 32'(n), 32'hA);
        rd_reg(ADDR_CTRL, rd);
        chk("state code", {29'h0, rd[18:16]}, 32'h5);
        @(posedge clk);
        first_wake_done <= 1'b0;
        wr_reg(ADDR_CTRL, 32'h0000_0002);
        stay(CODE_SLEEP1, 32'h0003_0122, 1'b1, 99, n);
        chk("sleep1 cycles", 32'(n), 32'h8);
        stay(CODE_SLEEP2, 32'h0000_0202, 1'b1, 99, n);
        chk("sleep2 cycles", 32'(n), 32'h1);
        stay(CODE_ASLEEP, CFG_ASLEEP, 1'b1, 5, n);
        chk("asleep cycles", 32'(n), 32'h5);
        // Slow rails: wake2 must outlast its dwell until every enabled rail is good
        @(posedge clk);
        slow <= 1'b1;
        wake_event <= 1'b1;
        @(negedge clk);
        stay(CODE_WAKE1, CFG_WAKE1, 1'b1, 1, n);
        @(posedge clk);
        wake_event <= 1'b0;
        first_wake_done <= 1'b1;
        @(negedge clk);
        stay(CODE_WAKE2, 32'h0002_0033, 1'b1, 99, n);
        chk("slow wake2 held", {31'h0, n > 4 && n < 20}, 32'h1);
        // Mid-run reset: outputs drop and the WAKE2 register reads back its reset value
        @(posedge clk);
        sys_rst <= 1'b1;
        first_wake_done <= 1'b0;
        slow <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("state in reset", seq_state, CODE_RESET);
        chk("outputs in reset", {25'h0, core_clk_off, analog_conv_pfm, core_conv_pfm,
            io_supply_en, pll_reg_en, analog_conv_en, core_conv_en}, 32'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        stay(CODE_WAKE1, CFG_WAKE1, 1'b1, 1, n);
        rd_reg(ADDR_WAKE2, rd);
        chk("wake2 after reset", rd, RST_WAKE2);
        close_out();
    end
endmodule : tb_power_state_supply_config
